// *** hdl/qgb_cfg.svh ***
`ifndef QGB_CFG_SVH
`define QGB_CFG_SVH

// register indices; byte address on the bus is four times the index
`define QGB_IDX_ACT 8'h30
`define QGB_IDX_DIR_FIVE 8'hE0
`define QGB_IDX_DATA_FIVE 8'hE1
`define QGB_IDX_INV_FIVE 8'hE2
`define QGB_IDX_DIR_TWO 8'hE3
`define QGB_IDX_DATA_TWO 8'hE4
`define QGB_IDX_INV_TWO 8'hE5
`define QGB_IDX_EVT_TWO 8'hE6
`define QGB_IDX_EVT_THREE 8'hE7
`define QGB_IDX_EVT_FOUR 8'hE8
`define QGB_IDX_EVT_FIVE 8'hE9
`define QGB_IDX_DIR_THREE 8'hF0
`define QGB_IDX_DATA_THREE 8'hF1
`define QGB_IDX_INV_THREE 8'hF2
`define QGB_IDX_DIR_FOUR 8'hF4
`define QGB_IDX_DATA_FOUR 8'hF5
`define QGB_IDX_INV_FOUR 8'hF6
`define QGB_IDX_MASK_TWO 8'hF8
`define QGB_IDX_MASK_THREE 8'hF9
`define QGB_IDX_MASK_FOUR 8'hFA
`define QGB_IDX_MASK_FIVE 8'hFB

// address field positions
`define QGB_ADR_IDX_MSB 9
`define QGB_ADR_IDX_LSB 2
`define QGB_ADR_HI_LSB 10

// reset values
`define QGB_DIR_RST 8'hFF
`define QGB_BYTE_RST 8'h00
`define QGB_ACT_RST 4'h0
`define QGB_ALL_BITS 8'hFF

`endif

// *** hdl/qgb_gpio_bank.sv ***
// Operation
// - activation register bits 3..0 enable banks five, four, three, two
// - direction bit 0 makes pin output, 1 input; resets to all ones
// - output pins: data bit written drives pin, reads back written value
// - input pins: data read returns sampled pin, writes to those bits ignored
// - inversion bit 1 inverts between data bit and pin, both directions
// - any rising or falling pin edge on an active bank sets sticky event status bit
// - reading event status clears it; status registers are read-only
// - event status bit n belongs to pin n of its bank
// - reset clears data, inversion, event status and activation registers
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "qgb_cfg.svh"

module qgb_gpio_bank (
  input wire logic clk_sys_in, // 100 MHz system clock
  input wire logic reset_n_in, // synchronous reset, active low
  input wire logic wb_cyc_in, // wishbone cycle
  input wire logic wb_stb_in, // wishbone strobe
  input wire logic wb_we_in, // wishbone write enable
  input wire logic [31:0] wb_adr_in, // wishbone byte address
  input wire logic [3:0] wb_sel_in, // wishbone byte lanes
  input wire logic [31:0] wb_dat_in, // wishbone write data
  output logic [31:0] wb_dat_out, // wishbone read data
  output logic wb_ack_out, // wishbone acknowledge
  input wire logic [3:0][7:0] bank_pins_in, // pin levels, banks five..two
  output qgb_pkg::qgb_pins_t pins_out, // pin drive level and enable_n
  output logic irq_out // unmasked event pending
);

  // per-bank register indices, index 0 is bank two
  localparam logic [3:0][7:0] DIR_IDX = {`QGB_IDX_DIR_FIVE, `QGB_IDX_DIR_FOUR,
                                         `QGB_IDX_DIR_THREE, `QGB_IDX_DIR_TWO};
  localparam logic [3:0][7:0] DATA_IDX = {`QGB_IDX_DATA_FIVE, `QGB_IDX_DATA_FOUR,
                                          `QGB_IDX_DATA_THREE, `QGB_IDX_DATA_TWO};
  localparam logic [3:0][7:0] INV_IDX = {`QGB_IDX_INV_FIVE, `QGB_IDX_INV_FOUR,
                                         `QGB_IDX_INV_THREE, `QGB_IDX_INV_TWO};
  localparam logic [3:0][7:0] EVT_IDX = {`QGB_IDX_EVT_FIVE, `QGB_IDX_EVT_FOUR,
                                         `QGB_IDX_EVT_THREE, `QGB_IDX_EVT_TWO};
  localparam logic [3:0][7:0] MASK_IDX = {`QGB_IDX_MASK_FIVE, `QGB_IDX_MASK_FOUR,
                                          `QGB_IDX_MASK_THREE, `QGB_IDX_MASK_TWO};

  qgb_pkg::qgb_state_t s_q;
  qgb_pkg::qgb_state_t s_d;
  logic hit;
  logic wr;
  logic rde;
  logic [7:0] idx;
  logic [7:0] rd;

  // bus decode; upper address bits must be zero to reach any register
  assign hit = wb_cyc_in & wb_stb_in & ~s_q.ack
               & (wb_adr_in[31:`QGB_ADR_HI_LSB] == '0);
  assign wr = hit & wb_we_in & wb_sel_in[0];
  assign rde = hit & ~wb_we_in;
  assign idx = wb_adr_in[`QGB_ADR_IDX_MSB:`QGB_ADR_IDX_LSB];

  // next-state logic for the whole block
  always_comb begin
    logic [7:0] pin_val;
    logic [7:0] edges;
    logic [7:0] clr;
    logic irq_any;
    s_d = s_q;
    rd = `QGB_BYTE_RST;
    irq_any = 1'b0;
    pin_val = `QGB_BYTE_RST;
    edges = `QGB_BYTE_RST;
    clr = `QGB_BYTE_RST;
    // ack lasts one cycle, so a held request is answered again every second cycle
    s_d.ack = wb_cyc_in & wb_stb_in & ~s_q.ack;
    if (idx == `QGB_IDX_ACT) begin
      rd = {4'h0, s_q.act};
      if (wr) begin
        s_d.act = wb_dat_in[3:0];
      end
    end
    for (int b = 0; b < 4; b++) begin
      // two-stage synchroniser, third stage holds the previous sample
      s_d.bank[b].sync1 = bank_pins_in[b];
      s_d.bank[b].sync2 = s_q.bank[b].sync1;
      s_d.bank[b].prev = s_q.bank[b].sync2;
      pin_val = s_q.bank[b].sync2 ^ s_q.bank[b].inv;
      edges = (s_q.bank[b].sync2 ^ s_q.bank[b].prev) & {8{s_q.act[b]}};
      clr = `QGB_BYTE_RST;
      if (idx == DIR_IDX[b]) begin
        rd = s_q.bank[b].dir;
        if (wr) begin
          s_d.bank[b].dir = wb_dat_in[7:0];
        end
      end
      if (idx == DATA_IDX[b]) begin
        // inputs read the pin, outputs read back the latch
        rd = (s_q.bank[b].dir & pin_val) | (~s_q.bank[b].dir & s_q.bank[b].data);
        if (wr) begin
          s_d.bank[b].data = (s_q.bank[b].dir & s_q.bank[b].data)
                             | (~s_q.bank[b].dir & wb_dat_in[7:0]);
        end
      end
      if (idx == INV_IDX[b]) begin
        rd = s_q.bank[b].inv;
        if (wr) begin
          s_d.bank[b].inv = wb_dat_in[7:0];
        end
      end
      if (idx == EVT_IDX[b]) begin
        rd = s_q.bank[b].evt;
        if (rde) begin
          clr = `QGB_ALL_BITS;
        end
      end
      if (idx == MASK_IDX[b]) begin
        rd = s_q.bank[b].mask;
        if (wr) begin
          s_d.bank[b].mask = wb_dat_in[7:0];
        end
      end
      // a new edge wins over a clearing read in the same cycle
      s_d.bank[b].evt = (s_q.bank[b].evt & ~clr) | edges;
      s_d.pins.level[b] = s_q.bank[b].data ^ s_q.bank[b].inv;
      s_d.pins.oe_n[b] = s_q.bank[b].dir | {8{~s_q.act[b]}};
      irq_any = irq_any | (|(s_d.bank[b].evt & s_d.bank[b].mask));
    end
    s_d.irq = irq_any;
    // unmapped reads answer zero; write data is ignored there
    s_d.rdat = rde ? {24'h0, rd} : '0;
    if (!reset_n_in) begin
      s_d = '0;
      s_d.act = `QGB_ACT_RST;
      for (int b = 0; b < 4; b++) begin
        s_d.bank[b].dir = `QGB_DIR_RST;
        s_d.pins.oe_n[b] = `QGB_ALL_BITS;
      end
    end
  end

  // single state register
  always_ff @(posedge clk_sys_in) begin
    s_q <= s_d;
  end

  assign wb_dat_out = s_q.rdat;
  assign wb_ack_out = s_q.ack;
  assign pins_out = s_q.pins;
  assign irq_out = s_q.irq;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);

  // an inactive bank releases every pin of that bank
  property p_inactive_release;
    !s_q.act[0] |=> (s_q.pins.oe_n[0] == `QGB_ALL_BITS);
  endproperty
  a_inactive_release: assert property (p_inactive_release)
    else $error("inactive bank two still drives a pin");

  // an input-configured pin is never driven
  property p_input_not_driven;
    s_q.bank[1].dir[3] |=> s_q.pins.oe_n[1][3];
  endproperty
  a_input_not_driven: assert property (p_input_not_driven)
    else $error("input pin of bank three is driven");

  // an active output pin is driven with data xor inversion
  property p_output_level;
    (s_q.act[0] && !s_q.bank[0].dir[1]) |=>
      (!s_q.pins.oe_n[0][1] &&
       s_q.pins.level[0][1] == ($past(s_q.bank[0].data[1]) ^ $past(s_q.bank[0].inv[1])));
  endproperty
  a_output_level: assert property (p_output_level)
    else $error("output pin level does not follow data and inversion");

  // writes to data bits of input pins leave them unchanged
  property p_input_write_ignored;
    (wr && idx == `QGB_IDX_DATA_TWO && s_q.bank[0].dir == `QGB_DIR_RST) |=>
      (s_q.bank[0].data == $past(s_q.bank[0].data));
  endproperty
  a_input_write_ignored: assert property (p_input_write_ignored)
    else $error("write changed data bits of input pins");

  // data read returns pin xor inversion for inputs and the latch for outputs
  property p_data_read;
    (rde && idx == `QGB_IDX_DATA_FIVE) |=>
      (wb_ack_out && wb_dat_out[7:0] ==
       (($past(s_q.bank[3].dir) & ($past(s_q.bank[3].sync2) ^ $past(s_q.bank[3].inv)))
        | (~$past(s_q.bank[3].dir) & $past(s_q.bank[3].data))));
  endproperty
  a_data_read: assert property (p_data_read)
    else $error("data register read value wrong");

  // an edge on an active pin sets its status bit on the next edge, even under a read
  property p_edge_sets;
    (s_q.act[3] && (s_q.bank[3].sync2[3] != s_q.bank[3].prev[3])) |=> s_q.bank[3].evt[3];
  endproperty
  a_edge_sets: assert property (p_edge_sets)
    else $error("edge on bank five pin three not recorded");

  // status bit stays set until a read of its register
  property p_evt_sticky;
    (s_q.bank[0].evt[2] && !(rde && idx == `QGB_IDX_EVT_TWO)) |=> s_q.bank[0].evt[2];
  endproperty
  a_evt_sticky: assert property (p_evt_sticky)
    else $error("event status bit dropped without a read");

  // a read with no new edge empties the status register
  property p_read_clears;
    (rde && idx == `QGB_IDX_EVT_THREE && !s_q.act[1]) |=>
      (s_q.bank[1].evt == `QGB_BYTE_RST) ##1 (s_q.bank[1].evt == `QGB_BYTE_RST);
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("event status not cleared by read");

  // a status bit stays clear while no pin of its bank changes
  property p_bit_map;
    (s_q.act[2] && s_q.bank[2].sync2 == s_q.bank[2].prev && !s_q.bank[2].evt[0]
     && !(rde && idx == `QGB_IDX_EVT_FOUR)) |=> !s_q.bank[2].evt[0];
  endproperty
  a_bit_map: assert property (p_bit_map)
    else $error("status bit set without an edge on its own pin");

  // inactive bank records no events
  property p_inactive_no_event;
    (!s_q.act[0] && !s_q.bank[0].evt[4]) |=> !s_q.bank[0].evt[4];
  endproperty
  a_inactive_no_event: assert property (p_inactive_no_event)
    else $error("inactive bank recorded an event");

  // state after reset release
  property p_reset_values;
    $rose(reset_n_in) |->
      (s_q.act == `QGB_ACT_RST && s_q.bank[0].data == `QGB_BYTE_RST &&
       s_q.bank[3].inv == `QGB_BYTE_RST && s_q.bank[1].evt == `QGB_BYTE_RST &&
       s_q.bank[2].dir == `QGB_DIR_RST && !irq_out);
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("register not at reset value after reset");

  // every request gets a single-cycle ack one cycle later
  property p_ack_pulse;
    (wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out ##1 !wb_ack_out;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("wishbone ack not a single pulse");

  // interrupt follows unmasked status
  property p_irq_level;
    (s_q.bank[0].evt & s_q.bank[0].mask) != '0 |-> irq_out;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt low with unmasked status set");

  // an activation write takes the low four data bits; reserved bits are dropped
  property p_act_write;
    (wr && idx == `QGB_IDX_ACT) |=> (s_q.act == $past(wb_dat_in[3:0]));
  endproperty
  a_act_write: assert property (p_act_write)
    else $error("activation register did not take written value");

  // direction register stores every bit as written
  property p_dir_write;
    (wr && idx == `QGB_IDX_DIR_TWO) |=> (s_q.bank[0].dir == $past(wb_dat_in[7:0]));
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction register did not take written value");

  // output bits of the data register take the written value
  property p_output_write;
    (wr && idx == `QGB_IDX_DATA_TWO) |=>
      ((s_q.bank[0].data & ~$past(s_q.bank[0].dir)) ==
       ($past(wb_dat_in[7:0]) & ~$past(s_q.bank[0].dir)));
  endproperty
  a_output_write: assert property (p_output_write)
    else $error("output data bits did not take written value");

  // input bits keep their old latch value across any data write
  property p_input_bits_kept;
    (wr && idx == `QGB_IDX_DATA_TWO) |=>
      ((s_q.bank[0].data & $past(s_q.bank[0].dir)) ==
       ($past(s_q.bank[0].data) & $past(s_q.bank[0].dir)));
  endproperty
  a_input_bits_kept: assert property (p_input_bits_kept)
    else $error("data write altered an input bit");

  // drive level is always latch xor inversion, so a later direction flip is glitch-free
  property p_level_follows;
    s_q.act[0] |=>
      (s_q.pins.level[0] == ($past(s_q.bank[0].data) ^ $past(s_q.bank[0].inv)));
  endproperty
  a_level_follows: assert property (p_level_follows)
    else $error("drive level is not data xor inversion");

  // a write to a status register never clears a pending bit
  property p_evt_write_ignored;
    (wr && idx == `QGB_IDX_EVT_TWO) |=>
      ((s_q.bank[0].evt & $past(s_q.bank[0].evt)) == $past(s_q.bank[0].evt));
  endproperty
  a_evt_write_ignored: assert property (p_evt_write_ignored)
    else $error("write cleared event status");

  // a status read returns the bits pending before the clear
  property p_evt_read_value;
    (rde && idx == `QGB_IDX_EVT_TWO) |=> (wb_dat_out[7:0] == $past(s_q.bank[0].evt));
  endproperty
  a_evt_read_value: assert property (p_evt_read_value)
    else $error("event status read value wrong");

  // with no edge in the read cycle, the read leaves nothing pending
  property p_read_clears_two;
    (rde && idx == `QGB_IDX_EVT_TWO && s_q.bank[0].sync2 == s_q.bank[0].prev) |=>
      (s_q.bank[0].evt == `QGB_BYTE_RST);
  endproperty
  a_read_clears_two: assert property (p_read_clears_two)
    else $error("bank two status not cleared by read");

  // falling edges count as well as rising ones
  property p_fall_sets;
    (s_q.act[0] && s_q.bank[0].prev[0] && !s_q.bank[0].sync2[0]) |=> s_q.bank[0].evt[0];
  endproperty
  a_fall_sets: assert property (p_fall_sets)
    else $error("falling edge on bank two pin zero not recorded");

  // pins reach logic only after two flops; skipped while reset flushes the chain
  property p_sync_delay;
    ($past(reset_n_in) && $past(reset_n_in, 2)) |->
      (s_q.bank[0].sync2 == $past(bank_pins_in[0], 2));
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("pin sample not two cycles behind the pin");

  // bank five is released while inactive
  property p_five_release;
    !s_q.act[3] |=> (s_q.pins.oe_n[3] == `QGB_ALL_BITS);
  endproperty
  a_five_release: assert property (p_five_release)
    else $error("inactive bank five still drives a pin");

  // read data is zero outside the answer cycle
  property p_rdat_idle;
    !wb_ack_out |-> (wb_dat_out == '0);
  endproperty
  a_rdat_idle: assert property (p_rdat_idle)
    else $error("read data not zero outside the ack cycle");

  // interrupt is low once no unmasked status bit remains in any bank
  property p_irq_low;
    ((s_q.bank[0].evt & s_q.bank[0].mask) | (s_q.bank[1].evt & s_q.bank[1].mask)
     | (s_q.bank[2].evt & s_q.bank[2].mask) | (s_q.bank[3].evt & s_q.bank[3].mask)) == '0
      |-> !irq_out;
  endproperty
  a_irq_low: assert property (p_irq_low)
    else $error("interrupt high with no unmasked status");

  // inversion register stores every bit as written
  property p_inv_write;
    (wr && idx == `QGB_IDX_INV_TWO) |=> (s_q.bank[0].inv == $past(wb_dat_in[7:0]));
  endproperty
  a_inv_write: assert property (p_inv_write)
    else $error("inversion register did not take written value");

endmodule

// *** hdl/qgb_pkg.sv ***
package qgb_pkg;

  typedef logic [7:0] qgb_byte_t;

  // per-bank configuration and pin sampling state
  typedef struct packed {
    qgb_byte_t dir;
    qgb_byte_t data;
    qgb_byte_t inv;
    qgb_byte_t evt;
    qgb_byte_t mask;
    qgb_byte_t sync1;
    qgb_byte_t sync2;
    qgb_byte_t prev;
  } qgb_bank_t;

  // pin drive bundle for the four banks
  typedef struct packed {
    logic [3:0][7:0] level;
    logic [3:0][7:0] oe_n;
  } qgb_pins_t;

  // whole block state
  typedef struct packed {
    logic [3:0] act;
    qgb_bank_t [3:0] bank;
    logic ack;
    logic [31:0] rdat;
    logic irq;
    qgb_pins_t pins;
  } qgb_state_t;

endpackage

// *** sim/qgb_gpio_bank_tb_top.sv ***
`timescale 1ns/1ps
`include "qgb_cfg.svh"
module qgb_gpio_bank_tb_top;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [31:0] adr = 32'h0, wdat = 32'h0, rdat;
  logic [3:0] sel = 4'hF;
  logic ack, irq;
  logic [3:0][7:0] ext = '0, pin_lvl;
  qgb_pkg::qgb_pins_t pins;
  int err_total = 0;
  int n_compared = 0;
  logic [31:0] rd;
  logic [7:0] idx_list [22] = '{8'h30, 8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hE6,
    8'hE7, 8'hE8, 8'hE9, 8'hF0, 8'hF1, 8'hF2, 8'hF4, 8'hF5, 8'hF6, 8'hF8, 8'hF9, 8'hFA,
    8'hFB, 8'hF3};
  logic [7:0] evt_idx [4] = '{`QGB_IDX_EVT_TWO, `QGB_IDX_EVT_THREE, `QGB_IDX_EVT_FOUR,
    `QGB_IDX_EVT_FIVE};

  always #5 clk_sys_in = ~clk_sys_in;

  qgb_gpio_bank DUT (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .bank_pins_in(pin_lvl), .pins_out(pins),
    .irq_out(irq));
  qgb_pin_model board (.pins_in(pins), .ext_in(ext), .wire_out(pin_lvl));

  task automatic conclude();
    if (err_total == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one classic cycle; request held until the edge that samples ack
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_sys_in);
    chk("ack idle", 0, ack);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {22'h0, idx, 2'b00};
    wdat <= {24'h0, d};
    // no cycle count assumed here; only the watchdog ends a hung wait
    do begin
      @(posedge clk_sys_in);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk($sformatf("reg %h", idx), {24'h0, exp}, rd);
  endtask

  task automatic settle();
    repeat (5) @(posedge clk_sys_in);
  endtask

  initial begin
    #50000;
    err_total++;
    conclude();
  end

  initial begin
    repeat (3) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    // reset values; direction registers start as inputs, F3 is unmapped
    foreach (idx_list[i]) begin
      rchk(idx_list[i], (idx_list[i] inside {8'hE0, 8'hE3, 8'hF0, 8'hF4}) ? 8'hFF : 8'h00);
    end
    wb(1'b1, 8'hF3, 8'h5A);
    rchk(8'hF3, 8'h00);
    // bank two: low nibble outputs, high nibble inputs from the board
    ext[0] <= 8'h30;
    wb(1'b1, `QGB_IDX_ACT, 8'h01);
    wb(1'b1, `QGB_IDX_DATA_TWO, 8'hA5);
    wb(1'b1, `QGB_IDX_DIR_TWO, 8'hF0);
    wb(1'b1, `QGB_IDX_DATA_TWO, 8'hA5);
    settle();
    rchk(`QGB_IDX_DATA_TWO, 8'h35);
    chk("oe_n two", 8'hF0, pins.oe_n[0]);
    chk("level two", 8'h05, pins.level[0]);
    chk("oe_n three", 8'hFF, pins.oe_n[1]);
    // outputs configured on an inactive bank must stay released
    wb(1'b1, `QGB_IDX_DIR_THREE, 8'h00);
    settle();
    chk("oe_n inactive", 8'hFF, pins.oe_n[1]);
    wb(1'b1, `QGB_IDX_DIR_THREE, 8'hFF);
    wb(1'b0, `QGB_IDX_EVT_TWO, 8'h00);
    // inverting flips the driven nibble, which the pins see as four edges
    wb(1'b1, `QGB_IDX_INV_TWO, 8'hFF);
    settle();
    chk("level inv", 8'h0A, pins.level[0] & 8'h0F);
    rchk(`QGB_IDX_DATA_TWO, 8'hC5);
    rchk(`QGB_IDX_EVT_TWO, 8'h0F);
    // unmasked input edge raises the interrupt until the status read
    wb(1'b1, `QGB_IDX_MASK_TWO, 8'h80);
    chk("irq idle", 0, irq);
    ext[0] <= 8'hB0;
    settle();
    chk("irq set", 1, irq);
    wb(1'b1, `QGB_IDX_EVT_TWO, 8'h00);
    rchk(`QGB_IDX_EVT_TWO, 8'h80);
    settle();
    chk("irq clr", 0, irq);
    rchk(`QGB_IDX_EVT_TWO, 8'h00);
    // each activation bit of banks three to five opens only its own bank to new events
    for (int b = 1; b < 4; b++) begin
      wb(1'b1, `QGB_IDX_ACT, 8'h01 | (8'h01 << b));
      for (int c = 1; c < 4; c++) ext[c] <= ext[c] ^ (8'h01 << b);
      settle();
      for (int c = 1; c < 4; c++) rchk(evt_idx[c], (c == b) ? (8'h01 << b) : 8'h00);
    end
    conclude();
  end
endmodule

// *** sim/qgb_pin_model.sv ***
`timescale 1ns/1ps
// board side of the pins: a pin that the block does not drive shows the board level
module qgb_pin_model (
  input wire qgb_pkg::qgb_pins_t pins_in, // block drive level and enable_n
  input wire logic [3:0][7:0] ext_in, // board drive for undriven pins
  output logic [3:0][7:0] wire_out // resolved pin level
);
  // board drivers are always present, so no pin ever floats
  assign wire_out = (pins_in.oe_n & ext_in) | (~pins_in.oe_n & pins_in.level);
endmodule
